//--- design/udfs_params.svh
// Register map, field positions, reset values and timing counts
`ifndef UDFS_PARAMS_SVH
`define UDFS_PARAMS_SVH

`define UDFS_OFS_FRAME 8'h00
`define UDFS_OFS_GLB 8'h04
`define UDFS_OFS_FADDR 8'h08
`define UDFS_OFS_IRQ_EN 8'h10
`define UDFS_OFS_IRQ_DIS 8'h14
`define UDFS_OFS_IRQ_MASK 8'h18
`define UDFS_OFS_IRQ_STAT 8'h1C
`define UDFS_OFS_IRQ_CLR 8'h20
`define UDFS_OFS_EP_RST 8'h28
`define UDFS_OFS_EP_CTRL 8'h30
`define UDFS_OFS_EP_DATA 8'h50
`define UDFS_OFS_TXVC 8'h74
`define UDFS_EP_STRIDE 8'h04
`define UDFS_EP_NUM 8

`define UDFS_BIT_FRAME_ERR 16
`define UDFS_BIT_FRAME_OK 17
`define UDFS_BIT_BYTE_OK 4
`define UDFS_BIT_BYTE_ERR 3
`define UDFS_BIT_ADDR_EN 0
`define UDFS_BIT_CONFIG 1
`define UDFS_BIT_RESUME 2
`define UDFS_BIT_RSM_BUSY 3
`define UDFS_BIT_RWU_EN 4
`define UDFS_BIT_FUNC_EN 8
`define UDFS_BIT_SOF_IRQ 11
`define UDFS_BIT_BUS_END 12
`define UDFS_IRQ_BITS 14

`define UDFS_RST_GLB 32'h0000_0010
`define UDFS_RST_FADDR 32'h0000_0100
`define UDFS_RST_IRQ_MASK 14'h1200
`define UDFS_RST_TXVC 32'h0000_0100
`define UDFS_TXVC_MASK 32'h0000_0300

`define UDFS_CLK_HZ 40000000
`define UDFS_K_TIME_MS 10
`define UDFS_K_CYCLES (`UDFS_K_TIME_MS * (`UDFS_CLK_HZ / 1000))

`endif

//--- design/udfs_pkg.sv
// Types shared by the device-port register front end
package udfs_pkg;
  typedef logic [31:0] udfs_word_type;
  typedef logic [7:0] udfs_addr_type;
  typedef logic [10:0] udfs_frame_type;
  typedef enum logic [0:0] {
    UDFS_WAKE_IDLE = 1'b0,
    UDFS_WAKE_DRIVE = 1'b1
  } udfs_wake_type;
endpackage : udfs_pkg

//--- design/udfs_core_if.sv
// Signals between the register front end and its frame and wake-up units
`timescale 1ns/1ps
interface udfs_core_if;
  logic wake_start;
  logic wake_active;
  logic [10:0] frame_count;
  logic frame_good;
  logic frame_error;
  modport wake_mp (input wake_start, output wake_active);
  modport frame_mp (output frame_count, output frame_good,
                    output frame_error);
endinterface : udfs_core_if

//--- design/udfs_frame.sv
// Start-of-frame number capture with good and error flags
`timescale 1ns/1ps
module udfs_frame (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic frame_start_packet_id_i,
  input wire logic frame_start_packet_end_i,
  input wire logic sof_crc_err_i,
  input wire udfs_pkg::udfs_frame_type sof_frame_i,
  udfs_core_if.frame_mp core
);
  import udfs_pkg::*;

  udfs_frame_type frame_count_ff;
  logic frame_good_ff;
  logic frame_error_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      frame_count_ff <= 11'h000;
    end else if (frame_start_packet_end_i) begin
      frame_count_ff <= sof_frame_i;
    end
  end

  // End of packet wins: a new identifier cannot arrive before it
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      frame_good_ff <= 1'b0;
      frame_error_ff <= 1'b0;
    end else if (frame_start_packet_end_i) begin
      frame_good_ff <= ~sof_crc_err_i;
      frame_error_ff <= sof_crc_err_i;
    end else if (frame_start_packet_id_i) begin
      frame_good_ff <= 1'b0;
      frame_error_ff <= 1'b0;
    end
  end

  assign core.frame_count = frame_count_ff;
  assign core.frame_good = frame_good_ff;
  assign core.frame_error = frame_error_ff;
endmodule : udfs_frame

//--- design/udfs_wakeup.sv
// Remote wake-up K state generator with fixed hold time
`timescale 1ns/1ps
`include "udfs_params.svh"
module udfs_wakeup #(
  parameter int unsigned K_CYCLES = `UDFS_K_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  udfs_core_if.wake_mp core
);
  import udfs_pkg::*;

  localparam logic [19:0] K_LAST = 20'(K_CYCLES - 1);

  udfs_wake_type state_ff;
  logic [19:0] count_ff;

  // A trigger while driving is dropped; the host sees one resume
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state_ff <= UDFS_WAKE_IDLE;
      count_ff <= 20'h00000;
    end else begin
      unique case (state_ff)
        UDFS_WAKE_IDLE: begin
          if (core.wake_start) begin
            state_ff <= UDFS_WAKE_DRIVE;
            count_ff <= K_LAST;
          end
        end
        UDFS_WAKE_DRIVE: begin
          if (count_ff == 20'h00000) begin
            state_ff <= UDFS_WAKE_IDLE;
          end else begin
            count_ff <= count_ff - 20'h00001;
          end
        end
      endcase
    end
  end

  assign core.wake_active = (state_ff == UDFS_WAKE_DRIVE);
endmodule : udfs_wakeup

//--- design/udfs_top.sv
// Register front end of the USB device port, Avalon-MM slave
//
// Overview of operation
// - Endpoint control words decode at 0x030 plus four per endpoint.
// - Endpoint data words decode at 0x050 plus four, reset zero.
// - Frame count bits 10:0 load at each start-of-frame packet end.
// - Error flag bit 16 sets on bad packet end, clears on identifier.
// - Good flag bit 17 sets on clean packet end, clears on identifier.
// - Frame-start status bit rises on the identifier, not the end.
// - Byte-wide view: good flag at high bit 4, error at low bit 3; not decoded here, 32-bit reads only.
// - Address-state bit 0 sets on write 1; only reset clears it.
// - Configured bit 1 reads back and follows written value.
// - Resume bit 2 rising write starts wake-up when enabled.
// - Interrupt status has no defined reset value.
// - Bit 4 enables remote wake-up when set.
// - Seven-bit function address clears at reset.
// - End of bus reset restores interrupt mask and endpoint control.
// - Wake-up drives K state for a fixed time within 1 to 15 ms.
//
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "udfs_params.svh"
module udfs_top #(
  parameter int unsigned K_CYCLES = `UDFS_K_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire udfs_pkg::udfs_addr_type avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire udfs_pkg::udfs_word_type avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output udfs_pkg::udfs_word_type avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic frame_start_packet_id_i,
  input wire logic frame_start_packet_end_i,
  input wire logic sof_crc_err_i,
  input wire udfs_pkg::udfs_frame_type sof_frame_i,
  input wire logic bus_reset_end_i,
  input wire logic [7:0] ep_event_i,
  input wire logic suspend_i,
  input wire logic host_resume_i,
  input wire logic ext_resume_i,
  input wire logic bus_wakeup_i,
  output logic [6:0] function_address_o,
  output logic function_enable_o,
  output logic address_state_o,
  output logic configured_o,
  output logic k_state_o,
  output logic [7:0] endpoint_reset_o,
  output logic [1:0] transceiver_ctrl_o
);
  import udfs_pkg::*;

  localparam int EPN = `UDFS_EP_NUM;
  localparam int IRQN = `UDFS_IRQ_BITS;
  localparam udfs_addr_type CTRL_LAST =
    8'(`UDFS_OFS_EP_CTRL + `UDFS_EP_STRIDE * (EPN - 1));
  localparam udfs_addr_type DATA_LAST =
    8'(`UDFS_OFS_EP_DATA + `UDFS_EP_STRIDE * (EPN - 1));
  localparam udfs_word_type RST_GLB = `UDFS_RST_GLB;
  localparam udfs_word_type RST_FADDR = `UDFS_RST_FADDR;

  udfs_core_if core_if ();

  // Bus handshake: one wait state on every access
  logic ack_ff;
  logic req;
  logic rd_do;
  logic wr_do;
  udfs_word_type rdata_ff;
  udfs_word_type nxt_rdata;
  udfs_word_type be_mask;

  // Device state
  logic addr_state_ff;
  logic configured_ff;
  logic resume_bit_ff;
  logic wake_en_ff;
  logic [6:0] function_address_value_ff;
  logic func_en_ff;
  logic [IRQN-1:0] irq_mask_ff;
  logic [IRQN-1:0] irq_stat_ff;
  logic [IRQN-1:0] irq_events;
  logic [7:0] ep_rst_ff;
  udfs_word_type txvc_ff;
  udfs_word_type ep_ctrl_ff [EPN];
  udfs_word_type ep_data_ff [EPN];

  // Address decode
  logic hit_glb;
  logic hit_faddr;
  logic hit_ctrl;
  logic hit_data;
  logic [2:0] ctrl_idx;
  logic [2:0] data_idx;
  udfs_word_type wr_word;

  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_ff;
  assign rd_do = avs_read_i & ack_ff;
  assign wr_do = avs_write_i & ack_ff;
  assign avs_readdata_o = rdata_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  always_comb begin
    be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  end

  assign hit_glb = wr_do && (avs_address_i == `UDFS_OFS_GLB);
  assign hit_faddr = wr_do && (avs_address_i == `UDFS_OFS_FADDR);
  assign hit_ctrl = (avs_address_i >= `UDFS_OFS_EP_CTRL) &&
                    (avs_address_i <= CTRL_LAST) &&
                    (avs_address_i[1:0] == 2'b00);
  assign hit_data = (avs_address_i >= `UDFS_OFS_EP_DATA) &&
                    (avs_address_i <= DATA_LAST) &&
                    (avs_address_i[1:0] == 2'b00);
  assign ctrl_idx = 3'((avs_address_i - `UDFS_OFS_EP_CTRL) >> 2);
  assign data_idx = 3'((avs_address_i - `UDFS_OFS_EP_DATA) >> 2);
  // Write data with unselected byte lanes taken as zero
  assign wr_word = avs_writedata_i & be_mask;

  // Bit 0 only ever sets from software; either reset clears it
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      addr_state_ff <= 1'b0;
    end else if (bus_reset_end_i) begin
      addr_state_ff <= 1'b0;
    end else if (hit_glb && wr_word[`UDFS_BIT_ADDR_EN]) begin
      addr_state_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      configured_ff <= 1'b0;
    end else if (bus_reset_end_i) begin
      configured_ff <= 1'b0;
    end else if (hit_glb && avs_byteenable_i[0]) begin
      configured_ff <= avs_writedata_i[`UDFS_BIT_CONFIG];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      resume_bit_ff <= RST_GLB[`UDFS_BIT_RESUME];
      wake_en_ff <= RST_GLB[`UDFS_BIT_RWU_EN];
    end else if (hit_glb && avs_byteenable_i[0]) begin
      resume_bit_ff <= avs_writedata_i[`UDFS_BIT_RESUME];
      wake_en_ff <= avs_writedata_i[`UDFS_BIT_RWU_EN];
    end
  end

  // Trigger needs the old bit at 0 and the enable as it stood before
  assign core_if.wake_start = hit_glb && avs_byteenable_i[0] &&
    avs_writedata_i[`UDFS_BIT_RESUME] && !resume_bit_ff &&
    wake_en_ff;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      function_address_value_ff <= RST_FADDR[6:0];
    end else if (hit_faddr && avs_byteenable_i[0]) begin
      function_address_value_ff <= avs_writedata_i[6:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      func_en_ff <= RST_FADDR[`UDFS_BIT_FUNC_EN];
    end else if (hit_faddr && avs_byteenable_i[1]) begin
      func_en_ff <= avs_writedata_i[`UDFS_BIT_FUNC_EN];
    end
  end

  // Mask register: set by enable writes, cleared by disable writes
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_mask_ff <= `UDFS_RST_IRQ_MASK;
    end else if (bus_reset_end_i) begin
      irq_mask_ff <= `UDFS_RST_IRQ_MASK;
    end else if (wr_do && avs_address_i == `UDFS_OFS_IRQ_EN) begin
      irq_mask_ff <= irq_mask_ff | wr_word[IRQN-1:0];
    end else if (wr_do && avs_address_i == `UDFS_OFS_IRQ_DIS) begin
      irq_mask_ff <= irq_mask_ff & ~wr_word[IRQN-1:0];
    end
  end

  assign irq_events = {bus_wakeup_i, bus_reset_end_i, frame_start_packet_id_i,
                       ext_resume_i, host_resume_i, suspend_i,
                       ep_event_i};

  // Status is zeroed only for a clean start; software must not rely on it
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      irq_stat_ff <= '0;
    end else if (wr_do && avs_address_i == `UDFS_OFS_IRQ_CLR) begin
      irq_stat_ff <= (irq_stat_ff & ~wr_word[IRQN-1:0]) | irq_events;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_events;
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ep_rst_ff <= 8'h00;
    end else if (wr_do && avs_address_i == `UDFS_OFS_EP_RST &&
                 avs_byteenable_i[0]) begin
      ep_rst_ff <= avs_writedata_i[7:0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      txvc_ff <= `UDFS_RST_TXVC;
    end else if (wr_do && avs_address_i == `UDFS_OFS_TXVC) begin
      txvc_ff <= ((txvc_ff & ~be_mask) | wr_word) &
                 `UDFS_TXVC_MASK;
    end
  end

  for (genvar ep = 0; ep < EPN; ep++) begin : g_ep
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        ep_ctrl_ff[ep] <= 32'h0000_0000;
      end else if (bus_reset_end_i) begin
        ep_ctrl_ff[ep] <= 32'h0000_0000;
      end else if (wr_do && hit_ctrl && ctrl_idx == 3'(ep)) begin
        ep_ctrl_ff[ep] <= (ep_ctrl_ff[ep] & ~be_mask) | wr_word;
      end
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
        ep_data_ff[ep] <= 32'h0000_0000;
      end else if (wr_do && hit_data && data_idx == 3'(ep)) begin
        ep_data_ff[ep] <= (ep_data_ff[ep] & ~be_mask) | wr_word;
      end
    end
  end

  // Read mux; unmapped and write-only offsets return zero
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (hit_ctrl) begin
      nxt_rdata = ep_ctrl_ff[ctrl_idx];
    end else if (hit_data) begin
      nxt_rdata = ep_data_ff[data_idx];
    end else begin
      unique case (avs_address_i)
        // Byte-wide flag positions are not decoded: 32-bit bus only
        `UDFS_OFS_FRAME: begin
          nxt_rdata[10:0] = core_if.frame_count;
          nxt_rdata[`UDFS_BIT_FRAME_ERR] = core_if.frame_error;
          nxt_rdata[`UDFS_BIT_FRAME_OK] = core_if.frame_good;
        end
        `UDFS_OFS_GLB: begin
          nxt_rdata[`UDFS_BIT_ADDR_EN] = addr_state_ff;
          nxt_rdata[`UDFS_BIT_CONFIG] = configured_ff;
          nxt_rdata[`UDFS_BIT_RESUME] = resume_bit_ff;
          nxt_rdata[`UDFS_BIT_RSM_BUSY] = core_if.wake_active;
          nxt_rdata[`UDFS_BIT_RWU_EN] = wake_en_ff;
        end
        `UDFS_OFS_FADDR: begin
          nxt_rdata[6:0] = function_address_value_ff;
          nxt_rdata[`UDFS_BIT_FUNC_EN] = func_en_ff;
        end
        `UDFS_OFS_IRQ_MASK: begin
          nxt_rdata[IRQN-1:0] = irq_mask_ff;
          nxt_rdata[`UDFS_BIT_BUS_END] = 1'b1;
        end
        `UDFS_OFS_IRQ_STAT: begin
          nxt_rdata[IRQN-1:0] = irq_stat_ff;
        end
        `UDFS_OFS_EP_RST: begin
          nxt_rdata[7:0] = ep_rst_ff;
        end
        `UDFS_OFS_TXVC: begin
          nxt_rdata = txvc_ff;
        end
        default: begin
          nxt_rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // Captured in the wait cycle so data stand when waitrequest drops
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_ff <= 32'h0000_0000;
    end else if (avs_read_i && !ack_ff) begin
      rdata_ff <= nxt_rdata;
    end else if (rd_do) begin
      rdata_ff <= rdata_ff;
    end
  end

  udfs_frame u_frame (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .frame_start_packet_id_i(frame_start_packet_id_i),
    .frame_start_packet_end_i(frame_start_packet_end_i),
    .sof_crc_err_i(sof_crc_err_i),
    .sof_frame_i(sof_frame_i),
    .core(core_if.frame_mp)
  );

  udfs_wakeup #(
    .K_CYCLES(K_CYCLES)
  ) u_wakeup (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .core(core_if.wake_mp)
  );

  assign function_address_o = function_address_value_ff;
  assign function_enable_o = func_en_ff;
  assign address_state_o = addr_state_ff;
  assign configured_o = configured_ff;
  assign k_state_o = core_if.wake_active;
  assign endpoint_reset_o = ep_rst_ff;
  assign transceiver_ctrl_o = txvc_ff[9:8];
endmodule : udfs_top

//--- verif/udfs_top_assertions.sv
// Port-level assertions for the device-port register front end
`timescale 1ns/1ps
module udfs_top_checker #(
  parameter int unsigned K_CYCLES = 8
) (
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire udfs_pkg::udfs_addr_type avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire udfs_pkg::udfs_word_type avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire udfs_pkg::udfs_word_type avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic bus_reset_end_i,
  input wire logic [6:0] function_address_o,
  input wire logic address_state_o,
  input wire logic configured_o,
  input wire logic k_state_o
);
  import udfs_pkg::*;
  logic wr_glb;
  logic rd_ack;
  logic [31:0] hi_cnt_ff;
  assign wr_glb = avs_write_i && !avs_waitrequest_o
    && avs_address_i == 8'h04 && avs_byteenable_i[0];
  assign rd_ack = avs_read_i && !avs_waitrequest_o;
  // Counts K-state cycles so the hold time is checked without repetition
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      hi_cnt_ff <= 32'h0;
    end else begin
      hi_cnt_ff <= k_state_o ? hi_cnt_ff + 32'h1 : 32'h0;
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  property p_addr_set;
    wr_glb && avs_writedata_i[0] && !bus_reset_end_i |=> address_state_o;
  endproperty
  a_addr_set: assert property (p_addr_set)
    else $error("address state not entered");
  property p_addr_hold;
    address_state_o && !bus_reset_end_i |=> address_state_o;
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address state left without reset");
  property p_cfg;
    wr_glb && !bus_reset_end_i |=>
      configured_o == $past(avs_writedata_i[1]);
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("configured bit does not follow write");
  property p_wake_cause;
    $rose(k_state_o) |-> $past(wr_glb && avs_writedata_i[2]);
  endproperty
  a_wake_cause: assert property (p_wake_cause)
    else $error("K state without resume write");
  property p_k_len;
    $fell(k_state_o) |-> hi_cnt_ff == K_CYCLES;
  endproperty
  a_k_len: assert property (p_k_len)
    else $error("K state hold time wrong");
  property p_k_max;
    k_state_o |-> hi_cnt_ff < K_CYCLES;
  endproperty
  a_k_max: assert property (p_k_max)
    else $error("K state held too long");
  property p_faddr;
    !$stable(function_address_o) |->
      $past(avs_write_i && !avs_waitrequest_o && avs_address_i == 8'h08);
  endproperty
  a_faddr: assert property (p_faddr)
    else $error("function address changed without write");
  property p_bus_rst;
    bus_reset_end_i |=> !address_state_o && !configured_o;
  endproperty
  a_bus_rst: assert property (p_bus_rst)
    else $error("bus reset end kept device state");
  property p_rsvd;
    rd_ack && (avs_address_i inside {8'h0C, 8'h10, 8'h14, 8'h20, 8'h24,
      8'h2C, 8'h70} || avs_address_i >= 8'h78) |-> avs_readdata_o == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved offset read nonzero");
  property p_frame_bits;
    rd_ack && avs_address_i == 8'h00 |->
      avs_readdata_o[31:18] == 14'h0 && avs_readdata_o[17:16] != 2'h3;
  endproperty
  a_frame_bits: assert property (p_frame_bits)
    else $error("frame register flags inconsistent");
  c_wake: cover property ($rose(k_state_o));
  c_bus_rst: cover property (bus_reset_end_i);
  c_frame_ok: cover property (rd_ack && avs_address_i == 8'h00
    && avs_readdata_o[17]);
endmodule : udfs_top_checker

bind udfs_top udfs_top_checker #(.K_CYCLES(K_CYCLES)) chk (
  .clk_sys_i(clk_sys_i), .reset_i(reset_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
  .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .bus_reset_end_i(bus_reset_end_i),
  .function_address_o(function_address_o),
  .address_state_o(address_state_o), .configured_o(configured_o),
  .k_state_o(k_state_o)
);

//--- verif/udfs_host_model.sv
// Behavioural host side: frame-start packets and bus reset ends
`timescale 1ns/1ps
module udfs_host_model (
  input wire logic clk_sys_i,
  output logic frame_start_packet_id_o,
  output logic frame_start_packet_end_o,
  output logic sof_crc_err_o,
  output udfs_pkg::udfs_frame_type sof_frame_o,
  output logic bus_reset_end_o
);
  import udfs_pkg::*;
  initial begin
    frame_start_packet_id_o = 1'b0;
    frame_start_packet_end_o = 1'b0;
    sof_crc_err_o = 1'b0;
    sof_frame_o = 11'h0;
    bus_reset_end_o = 1'b0;
  end
  task automatic pulse_pid();
    @(posedge clk_sys_i);
    frame_start_packet_id_o <= 1'b1;
    @(posedge clk_sys_i);
    frame_start_packet_id_o <= 1'b0;
  endtask : pulse_pid
  task automatic send_eop(input udfs_frame_type fr, input logic err);
    @(posedge clk_sys_i);
    frame_start_packet_end_o <= 1'b1;
    sof_frame_o <= fr;
    sof_crc_err_o <= err;
    @(posedge clk_sys_i);
    frame_start_packet_end_o <= 1'b0;
    // Only valid with the end strobe; invert so stale data never matches
    sof_frame_o <= ~fr;
    sof_crc_err_o <= ~err;
  endtask : send_eop
  task automatic send_sof(input udfs_frame_type fr, input logic err);
    pulse_pid();
    repeat (3) @(posedge clk_sys_i);
    send_eop(fr, err);
  endtask : send_sof
  task automatic end_bus_reset();
    @(posedge clk_sys_i);
    bus_reset_end_o <= 1'b1;
    @(posedge clk_sys_i);
    bus_reset_end_o <= 1'b0;
  endtask : end_bus_reset
endmodule : udfs_host_model

//--- verif/tb_top.sv
// Self-checking bench: register bus sequences and frame traffic
`timescale 1ns/1ps
module tb_top;
  import udfs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  udfs_addr_type addr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  udfs_word_type wdata = 32'h0;
  logic [3:0] be = 4'hF;
  udfs_word_type rdata;
  logic wreq, pid, eop, cerr, bre, function_endpoints_enable, ast, cfg, k;
  udfs_frame_type frm;
  logic [6:0] fa;
  logic [7:0] ev = 8'h00;
  logic [7:0] epr;
  logic [1:0] txc;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  udfs_addr_type rsv[9] = '{8'h0C, 8'h10, 8'h14, 8'h20, 8'h24, 8'h2C,
    8'h70, 8'h78, 8'hFC};
  udfs_addr_type ra[6] = '{8'h00, 8'h04, 8'h08, 8'h18, 8'h28, 8'h74};
  udfs_word_type rv[6] = '{32'h0, 32'h10, 32'h100, 32'h1200, 32'h0,
    32'h100};
  always #12.5 clk = ~clk;
  udfs_host_model host (.clk_sys_i(clk), .frame_start_packet_id_o(pid), .frame_start_packet_end_o(eop),
    .sof_crc_err_o(cerr), .sof_frame_o(frm), .bus_reset_end_o(bre));
  udfs_top #(.K_CYCLES(8)) uut (.clk_sys_i(clk), .reset_i(rst),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .frame_start_packet_id_i(pid),
    .frame_start_packet_end_i(eop), .sof_crc_err_i(cerr), .sof_frame_i(frm),
    .bus_reset_end_i(bre), .ep_event_i(ev), .suspend_i(1'b0),
    .host_resume_i(1'b0), .ext_resume_i(1'b0), .bus_wakeup_i(1'b0),
    .function_address_o(fa), .function_enable_o(function_endpoints_enable),
    .address_state_o(ast), .configured_o(cfg), .k_state_o(k),
    .endpoint_reset_o(epr), .transceiver_ctrl_o(txc));
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input udfs_word_type ex,
                     input udfs_word_type got);
    checked++;
    if (got !== ex) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input udfs_addr_type a,
      input udfs_word_type d, input logic [3:0] l, output udfs_word_type q);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    be <= l;
    wr <= w;
    rd <= !w;
    // No wait-state count assumed; only the cycle ceiling ends a hang
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic wr32(input udfs_addr_type a, input udfs_word_type d);
    udfs_word_type q;
    bus(1'b1, a, d, 4'hF, q);
  endtask : wr32
  task automatic rdc(input string nm, input udfs_addr_type a,
                     input udfs_word_type ex);
    udfs_word_type q;
    bus(1'b0, a, 32'h0, 4'hF, q);
    chk(nm, ex, q);
  endtask : rdc
  task automatic pin(input string nm, input logic ex, input logic got);
    chk(nm, {31'h0, ex}, {31'h0, got});
  endtask : pin
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      final_report();
    end
  end
  initial begin
    udfs_word_type q;
    int i;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 6; i++) rdc("reset value", ra[i], rv[i]);
    for (i = 0; i < 8; i++) rdc("ep ctrl", 8'h30 + 8'(4 * i), 32'h0);
    for (i = 0; i < 8; i++) wr32(8'h50 + 8'(4 * i), 32'hA0 + 32'(i));
    for (i = 0; i < 8; i++)
      rdc("ep data", 8'h50 + 8'(4 * i), 32'hA0 + 32'(i));
    for (i = 0; i < 9; i++) wr32(rsv[i], 32'hFFFF_FFFF);
    for (i = 0; i < 9; i++) rdc("reserved", rsv[i], 32'h0);
    wr32(8'h00, 32'hFFFF_FFFF);
    rdc("frame ro", 8'h00, 32'h0);
    wr32(8'h74, 32'hFFFF_FFFF);
    rdc("txvc", 8'h74, 32'h300);
    chk("txvc pins", 32'h3, {30'h0, txc});
    wr32(8'h20, 32'h800);
    host.pulse_pid();
    bus(1'b0, 8'h1C, 32'h0, 4'hF, q);
    chk("sof status", 32'h800, q & 32'h800);
    host.send_eop(11'h5A5, 1'b0);
    rdc("frame good", 8'h00, 32'h0002_05A5);
    host.send_sof(11'h7FF, 1'b1);
    rdc("frame error", 8'h00, 32'h0001_07FF);
    host.pulse_pid();
    rdc("flags cleared", 8'h00, 32'h0000_07FF);
    wr32(8'h20, 32'h3FFF);
    ev <= 8'h81;
    @(posedge clk);
    ev <= 8'h00;
    host.pulse_pid();
    rdc("irq status", 8'h1C, 32'h881);
    wr32(8'h08, 32'h105);
    rdc("faddr", 8'h08, 32'h105);
    chk("faddr pins", 32'h85, {24'h0, function_endpoints_enable, fa});
    bus(1'b1, 8'h04, 32'h11, 4'hE, q);
    @(posedge clk);
    pin("lane off", 1'b0, ast);
    wr32(8'h04, 32'h11);
    wr32(8'h04, 32'h10);
    rdc("addr hold", 8'h04, 32'h11);
    wr32(8'h04, 32'h13);
    rdc("configured", 8'h04, 32'h13);
    wr32(8'h04, 32'h11);
    rdc("unconfigured", 8'h04, 32'h11);
    wr32(8'h04, 32'h17);
    rdc("resume busy", 8'h04, 32'h1F);
    i = 0;
    while (k !== 1'b0 && i < 40) begin
      @(posedge clk);
      i++;
    end
    rdc("resume done", 8'h04, 32'h17);
    wr32(8'h04, 32'h17);
    @(posedge clk);
    pin("no retrigger", 1'b0, k);
    wr32(8'h04, 32'h03);
    wr32(8'h04, 32'h07);
    @(posedge clk);
    pin("wake disabled", 1'b0, k);
    wr32(8'h04, 32'h13);
    wr32(8'h10, 32'h0F);
    wr32(8'h14, 32'h201);
    rdc("mask", 8'h18, 32'h100E);
    wr32(8'h4C, 32'h5A);
    rdc("ep ctrl wr", 8'h4C, 32'h5A);
    wr32(8'h28, 32'h1FF);
    rdc("ep reset", 8'h28, 32'hFF);
    chk("ep reset pins", 32'hFF, {24'h0, epr});
    host.end_bus_reset();
    @(posedge clk);
    rdc("mask restored", 8'h18, 32'h1200);
    rdc("ep ctrl cleared", 8'h4C, 32'h0);
    pin("addr cleared", 1'b0, ast);
    pin("cfg cleared", 1'b0, cfg);
    @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    rdc("reset faddr", 8'h08, 32'h100);
    rdc("reset glb", 8'h04, 32'h10);
    final_report();
  end
endmodule : tb_top
